// >>> dgf_pkg.sv
// shared constants and types for the diagnostic flag and table index block
package dgf_pkg;
  localparam int          CH_W      = 16;
  localparam int          NUM_CH    = 5;
  localparam int          IDX_W     = 7;
  localparam int          ADDR_W    = 8;
  localparam int          DATA_W    = 8;

  typedef logic [NUM_CH-1:0][CH_W-1:0] dgf_thr_t;

  // measurement channel codes
  localparam logic [2:0]  CH_TEMP   = 3'h0;
  localparam logic [2:0]  CH_VOLT   = 3'h1;
  localparam logic [2:0]  CH_BIAS   = 3'h2;
  localparam logic [2:0]  CH_TXP    = 3'h3;
  localparam logic [2:0]  CH_RXP    = 3'h4;

  // register offsets on the host read/write port
  localparam logic [7:0]  REG_ALARM_A = 8'h00;
  localparam logic [7:0]  REG_ALARM_B = 8'h01;
  localparam logic [7:0]  REG_WARN_A  = 8'h02;
  localparam logic [7:0]  REG_WARN_B  = 8'h03;
  localparam logic [7:0]  REG_INDEX   = 8'h04;
  localparam logic [7:0]  REG_FLAGCFG = 8'h05;
  localparam logic [7:0]  REG_CTRL    = 8'h06;

  localparam logic [7:0]  FLAGCFG_RST = 8'h00;
  localparam logic [7:0]  CTRL_RST    = 8'h0F;
  localparam int          CFG_MODE_MSB = 7;
  localparam int          CFG_MODE_LSB = 4;

  // open-drain pin positions in the pin vector and in the control register
  localparam int          PIN_TRS   = 0;
  localparam int          PIN_RRS   = 1;
  localparam int          PIN_GPO   = 2;
  localparam int          PIN_SECOND_GENERAL_OUTPUT  = 3;
  localparam int          PIN_LOS   = 4;
  localparam int          PIN_TXF   = 5;
  localparam int          NUM_PINS  = 6;

  // temperature averaging and table indexing
  localparam int          AVG_LOG2  = 4;
  localparam int          TEMP_INT_MSB = 15;
  localparam int          TEMP_INT_LSB = 8;
  localparam logic [6:0]  IDX_MAX   = 7'h4B;
  localparam logic [6:0]  IDX_SPLIT = 7'h40;
  localparam logic [7:0]  HYS_UP    = 8'h03;
  localparam logic [7:0]  HYS_DN    = 8'h02;

  // table bases: first page then continuation page
  localparam logic [7:0]  BASE_APC  = 8'h00;
  localparam logic [7:0]  BASE_MOD  = 8'h40;
  localparam logic [7:0]  BASE_FLT  = 8'h80;
  localparam logic [7:0]  BASE_BHA  = 8'hC0;
  localparam logic [7:0]  CONT_APC  = 8'h64;
  localparam logic [7:0]  CONT_MOD  = 8'h70;
  localparam logic [7:0]  CONT_FLT  = 8'h58;
  localparam logic [7:0]  CONT_BHA  = 8'h7C;
endpackage

// >>> dgf_temp_if.sv
// temperature samples in, table index and addresses out
`timescale 1ns/10ps
interface dgf_temp_if;
  logic                  sample_vld;
  logic [15:0]           sample;
  logic [6:0]            index;
  logic                  index_vld;
  logic [3:0][7:0]       tbl_addr;
  logic [3:0]            tbl_page;

  modport top (output sample_vld, output sample,
               input index, input index_vld, input tbl_addr, input tbl_page);
  modport lut (input sample_vld, input sample,
               output index, output index_vld, output tbl_addr, output tbl_page);
endinterface

// >>> dgf_thr_cmp.sv
// four-way threshold comparison of one conversion result
`timescale 1ns/10ps
module dgf_thr_cmp #(
  parameter int W = 16
) (
  input  wire logic [W-1:0] value_i,    // conversion result
  input  wire logic         signed_i,   // two's complement compare
  input  wire logic [W-1:0] alm_hi_i,   // high alarm threshold
  input  wire logic [W-1:0] alm_lo_i,   // low alarm threshold
  input  wire logic [W-1:0] wrn_hi_i,   // high warning threshold
  input  wire logic [W-1:0] wrn_lo_i,   // low warning threshold
  output logic [1:0]        alarm_o,    // {above high, below low}
  output logic [1:0]        warn_o      // {above high, below low}
);
  function automatic logic gt(input logic [W-1:0] a, input logic [W-1:0] b,
                              input logic sgn);
    gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  always_comb begin
    alarm_o = {gt(value_i, alm_hi_i, signed_i), gt(alm_lo_i, value_i, signed_i)};
    warn_o  = {gt(value_i, wrn_hi_i, signed_i), gt(wrn_lo_i, value_i, signed_i)};
  end
endmodule

// >>> dgf_lut_idx.sv
// sixteen-sample temperature average, hysteretic table index, table addresses
`timescale 1ns/10ps
module dgf_lut_idx (
  input  wire logic clk_i,              // system clock
  input  wire logic arst_n_i,           // async reset, active low
  dgf_temp_if.lut   tif                 // samples in, index out
);
  typedef enum logic [1:0] {
    DGF_ST_ACC  = 2'b01,
    DGF_ST_CALC = 2'b10
  } dgf_state_t;

  localparam int SUM_W = 16 + dgf_pkg::AVG_LOG2;

  dgf_state_t          state_ff,  nxt_state;
  logic [SUM_W-1:0]    sum_ff,    nxt_sum;
  logic [3:0]          cnt_ff,    nxt_cnt;
  logic [6:0]          index_ff,  nxt_index;
  logic                have_ff,   nxt_have;
  logic                vld_ff,    nxt_vld;
  logic [15:0]         avg;
  logic signed [7:0]   deg;
  logic [7:0]          mag;
  logic [7:0]          cur2;
  logic [6:0]          raw;

  always_comb begin
    avg = sum_ff[SUM_W-1:dgf_pkg::AVG_LOG2];
    deg = $signed(avg[dgf_pkg::TEMP_INT_MSB:dgf_pkg::TEMP_INT_LSB]);
    mag = deg[7] ? 8'(-deg) : 8'(deg);
    raw = (mag[7:1] > dgf_pkg::IDX_MAX) ? dgf_pkg::IDX_MAX : mag[7:1]; // see [RULE_14]
    cur2 = {index_ff, 1'b0};
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_sum   = sum_ff;
    nxt_cnt   = cnt_ff;
    nxt_index = index_ff;
    nxt_have  = have_ff;
    nxt_vld   = 1'b0;
    case (state_ff)
      DGF_ST_ACC: begin
        if (tif.sample_vld) begin
          nxt_sum = sum_ff + SUM_W'($signed(tif.sample)); // see [RULE_21]
          nxt_cnt = cnt_ff + 4'h1;
          if (cnt_ff == 4'hF) begin
            nxt_state = DGF_ST_CALC;
          end
        end
      end
      DGF_ST_CALC: begin
        // take the first average directly; after that move only past the midpoint of the neighbouring entry
        if (!have_ff || mag >= cur2 + dgf_pkg::HYS_UP ||
            (cur2 >= dgf_pkg::HYS_DN && mag <= cur2 - dgf_pkg::HYS_DN)) begin // see [RULE_22]
          nxt_index = raw;
        end
        nxt_have  = 1'b1;
        nxt_vld   = 1'b1; // see [RULE_13]
        nxt_sum   = '0;
        // a sample landing here opens the next group instead of being lost
        if (tif.sample_vld) begin
          nxt_sum = SUM_W'($signed(tif.sample)); // see [RULE_21]
          nxt_cnt = cnt_ff + 4'h1;
        end
        nxt_state = DGF_ST_ACC;
      end
      default: nxt_state = DGF_ST_ACC;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_ff <= DGF_ST_ACC;
      sum_ff   <= '0;
      cnt_ff   <= 4'h0;
      index_ff <= 7'h00;
      have_ff  <= 1'b0;
      vld_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sum_ff   <= nxt_sum;
      cnt_ff   <= nxt_cnt;
      index_ff <= nxt_index;
      have_ff  <= nxt_have;
      vld_ff   <= nxt_vld;
    end
  end

  function automatic logic [7:0] tbl_addr(input logic [6:0] idx, input logic [7:0] base,
                                          input logic [7:0] cont);
    tbl_addr = (idx < dgf_pkg::IDX_SPLIT) ? base + {1'b0, idx}
                                          : cont + {1'b0, idx - dgf_pkg::IDX_SPLIT};
  endfunction

  always_comb begin
    tif.index     = index_ff;
    tif.index_vld = vld_ff;
    tif.tbl_addr[0] = tbl_addr(index_ff, dgf_pkg::BASE_APC, dgf_pkg::CONT_APC); // see [RULE_15]
    tif.tbl_addr[1] = tbl_addr(index_ff, dgf_pkg::BASE_MOD, dgf_pkg::CONT_MOD); // see [RULE_17]
    tif.tbl_addr[2] = tbl_addr(index_ff, dgf_pkg::BASE_FLT, dgf_pkg::CONT_FLT); // see [RULE_18]
    tif.tbl_addr[3] = tbl_addr(index_ff, dgf_pkg::BASE_BHA, dgf_pkg::CONT_BHA); // see [RULE_19]
    tif.tbl_page    = {4{index_ff >= dgf_pkg::IDX_SPLIT}};
  end

  a_index_range: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see [RULE_14]
    index_ff <= dgf_pkg::IDX_MAX)
    else $error("table index beyond last entry");

  a_index_fresh: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see [RULE_13]
    (state_ff == DGF_ST_ACC && tif.sample_vld && cnt_ff == 4'hF) |=> ##1 vld_ff)
    else $error("no index update after sixteenth sample");
endmodule

// >>> dgf_top.sv
// alarm/warning flags, table index and open-drain status pins
`timescale 1ns/10ps
// Behaviour
// [RULE_01] temperature above/below alarm limits sets alarm_flags_a bits 7 and 6.
// [RULE_02] supply voltage above/below alarm limits sets alarm_flags_a bits 5 and 4.
// [RULE_03] bias current above/below alarm limits sets alarm_flags_a bits 3 and 2.
// [RULE_04] transmit power above/below alarm limits sets alarm_flags_a bits 1 and 0.
// [RULE_05] receive power above/below alarm limits sets alarm_flags_b bits 7 and 6.
// [RULE_06] temperature and voltage warnings set warning_flags_a bits 7 down to 4.
// [RULE_07] bias and transmit power warnings set warning_flags_a bits 3 down to 0.
// [RULE_08] receive power above/below warning limits sets warning_flags_b bits 7 and 6.
// [RULE_09] a true condition always sets its flag; nothing masks the set.
// [RULE_10] config bits 7..4 zero: flag holds until its register is read or reset.
// [RULE_11] transmit disable never stops evaluation or flag setting.
// [RULE_12] transmit disable falling clears every flag register.
// [RULE_13] each new temperature average produces a fresh table index.
// [RULE_14] index is the averaged temperature magnitude halved.
// [RULE_15] table address is index plus the table's base address.
// [RULE_16] current index is always readable in the index register.
// [RULE_17] modulation table: 40h-7Fh first page, 70h-7Bh continuation page.
// [RULE_18] bias fault table: 80h-BFh first page, 58h-63h continuation page.
// [RULE_19] bias alarm table: C0h-FFh first page, 7Ch-87h continuation page.
// [RULE_20] status pins are open-drain; control register reads actual pin levels.
// [RULE_21] the average is taken over sixteen successive temperature results.
// [RULE_22] index moves only past the midpoint of the neighbouring two-degree entry.
// [RULE_23] all four comparisons run whenever a channel's new result arrives.
module dgf_top (
  input  wire logic                   clk_i,          // system clock, 100 MHz
  input  wire logic                   arst_n_i,       // async reset, active low
  input  wire logic                   meas_vld_i,     // new conversion result pulse
  input  wire logic [2:0]             meas_chan_i,    // channel of the result
  input  wire logic [15:0]            meas_data_i,    // conversion result
  input  wire dgf_pkg::dgf_thr_t      alm_hi_i,       // high alarm limits per channel
  input  wire dgf_pkg::dgf_thr_t      alm_lo_i,       // low alarm limits per channel
  input  wire dgf_pkg::dgf_thr_t      wrn_hi_i,       // high warning limits per channel
  input  wire dgf_pkg::dgf_thr_t      wrn_lo_i,       // low warning limits per channel
  input  wire logic                   tx_disable_i,   // transmit disable input level
  input  wire logic                   los_det_i,      // internal loss-of-signal, high=release
  input  wire logic                   tx_fault_det_i, // internal transmit fault, high=release
  input  wire logic                   reg_rd_i,       // register read strobe
  input  wire logic                   reg_wr_i,       // register write strobe
  input  wire logic [7:0]             reg_addr_i,     // register offset
  input  wire logic [7:0]             reg_wdata_i,    // write data
  output logic [7:0]                  reg_rdata_o,    // read data, one cycle after strobe
  output logic                        reg_rvld_o,     // read data valid pulse
  input  wire logic [5:0]             od_pin_i,       // sensed level on open-drain pins
  output logic [5:0]                  od_pin_o,       // pin output value, always low
  output logic [5:0]                  od_pin_oe_n_o,  // low while pulling the pin low
  output logic [6:0]                  table_index_o,  // current table index
  output logic [31:0]                 tbl_addr_o,     // four table addresses, apc lowest
  output logic [3:0]                  tbl_page_o      // high: continuation page
);
  default clocking dgf_cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  dgf_temp_if tif ();

  logic [1:0]  cmp_alm, cmp_wrn;
  logic [9:0]  alm_vec, wrn_vec;
  logic [7:0]  alarm_flags_a_ff, nxt_alarm_flags_a;
  logic [7:0]  alarm_flags_b_ff, nxt_alarm_flags_b;
  logic [7:0]  warning_flags_a_ff, nxt_warning_flags_a;
  logic [7:0]  warning_flags_b_ff, nxt_warning_flags_b;
  logic [7:0]  flag_behaviour_config_ff, nxt_flag_behaviour_config;
  logic [7:0]  ctrl_ff, nxt_ctrl;
  logic        txdis_ff, nxt_txdis;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        rvld_ff, nxt_rvld;
  logic [5:0]  od_ff, nxt_od;
  logic        txdis_fall;
  logic        clr_on_rd;

  // decode of read strobes that clear a flag register
  function automatic logic rd_hit(input logic rd, input logic [7:0] a, input logic [7:0] off,
                                  input logic en);
    rd_hit = rd && en && (a == off);
  endfunction

  // one comparator serves every channel; results are routed by channel
  dgf_thr_cmp #(
    .W        (dgf_pkg::CH_W)
  ) u_cmp (
    .value_i  (meas_data_i),
    .signed_i (meas_chan_i == dgf_pkg::CH_TEMP),
    .alm_hi_i (alm_hi_i[meas_chan_i]),
    .alm_lo_i (alm_lo_i[meas_chan_i]),
    .wrn_hi_i (wrn_hi_i[meas_chan_i]),
    .wrn_lo_i (wrn_lo_i[meas_chan_i]),
    .alarm_o  (cmp_alm),
    .warn_o   (cmp_wrn)
  );

  dgf_lut_idx u_lut (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tif      (tif.lut)
  );

  always_comb begin
    tif.sample_vld = meas_vld_i && (meas_chan_i == dgf_pkg::CH_TEMP);
    tif.sample     = meas_data_i;
  end

  // channel c owns bits 9-2c (high) and 8-2c (low) of the 10-bit event vectors
  always_comb begin
    alm_vec = 10'h000;
    wrn_vec = 10'h000;
    if (meas_vld_i && meas_chan_i < 3'(dgf_pkg::NUM_CH)) begin // see [RULE_23] [RULE_11]
      alm_vec = 10'({cmp_alm, 8'h00} >> {meas_chan_i, 1'b0}); // see [RULE_01] [RULE_02]
      wrn_vec = 10'({cmp_wrn, 8'h00} >> {meas_chan_i, 1'b0}); // see [RULE_06] [RULE_07]
    end
  end

  always_comb begin
    nxt_txdis  = tx_disable_i;
    txdis_fall = txdis_ff && !tx_disable_i;
    clr_on_rd  = flag_behaviour_config_ff[dgf_pkg::CFG_MODE_MSB:dgf_pkg::CFG_MODE_LSB] == 4'h0;
    nxt_alarm_flags_a   = alarm_flags_a_ff;
    nxt_alarm_flags_b   = alarm_flags_b_ff;
    nxt_warning_flags_a = warning_flags_a_ff;
    nxt_warning_flags_b = warning_flags_b_ff;
    if (txdis_fall) begin // see [RULE_12]
      nxt_alarm_flags_a   = 8'h00;
      nxt_alarm_flags_b   = 8'h00;
      nxt_warning_flags_a = 8'h00;
      nxt_warning_flags_b = 8'h00;
    end
    if (rd_hit(reg_rd_i, reg_addr_i, dgf_pkg::REG_ALARM_A, clr_on_rd)) begin // see [RULE_10]
      nxt_alarm_flags_a = 8'h00;
    end
    if (rd_hit(reg_rd_i, reg_addr_i, dgf_pkg::REG_ALARM_B, clr_on_rd)) begin
      nxt_alarm_flags_b = 8'h00;
    end
    if (rd_hit(reg_rd_i, reg_addr_i, dgf_pkg::REG_WARN_A, clr_on_rd)) begin
      nxt_warning_flags_a = 8'h00;
    end
    if (rd_hit(reg_rd_i, reg_addr_i, dgf_pkg::REG_WARN_B, clr_on_rd)) begin
      nxt_warning_flags_b = 8'h00;
    end
    // set wins over any clear in the same cycle
    nxt_alarm_flags_a   = nxt_alarm_flags_a   | alm_vec[9:2]; // see [RULE_09] [RULE_03] [RULE_04]
    nxt_alarm_flags_b   = nxt_alarm_flags_b   | {alm_vec[1:0], 6'h00}; // see [RULE_05]
    nxt_warning_flags_a = nxt_warning_flags_a | wrn_vec[9:2]; // see [RULE_09]
    nxt_warning_flags_b = nxt_warning_flags_b | {wrn_vec[1:0], 6'h00}; // see [RULE_08]
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alarm_flags_a_ff   <= 8'h00;
      alarm_flags_b_ff   <= 8'h00;
      warning_flags_a_ff <= 8'h00;
      warning_flags_b_ff <= 8'h00;
      txdis_ff           <= 1'b0;
    end else begin
      alarm_flags_a_ff   <= nxt_alarm_flags_a;
      alarm_flags_b_ff   <= nxt_alarm_flags_b;
      warning_flags_a_ff <= nxt_warning_flags_a;
      warning_flags_b_ff <= nxt_warning_flags_b;
      txdis_ff           <= nxt_txdis;
    end
  end

  // register port and open-drain pin drive
  always_comb begin
    nxt_flag_behaviour_config = flag_behaviour_config_ff;
    nxt_ctrl = ctrl_ff;
    if (reg_wr_i && reg_addr_i == dgf_pkg::REG_FLAGCFG) begin
      nxt_flag_behaviour_config = reg_wdata_i;
    end
    if (reg_wr_i && reg_addr_i == dgf_pkg::REG_CTRL) begin
      nxt_ctrl = reg_wdata_i;
    end
    nxt_rvld  = reg_rd_i;
    nxt_rdata = rdata_ff;
    if (reg_rd_i) begin
      case (reg_addr_i)
        dgf_pkg::REG_ALARM_A: nxt_rdata = alarm_flags_a_ff;
        dgf_pkg::REG_ALARM_B: nxt_rdata = alarm_flags_b_ff;
        dgf_pkg::REG_WARN_A:  nxt_rdata = warning_flags_a_ff;
        dgf_pkg::REG_WARN_B:  nxt_rdata = warning_flags_b_ff;
        dgf_pkg::REG_INDEX:   nxt_rdata = {1'b0, tif.index}; // see [RULE_16]
        dgf_pkg::REG_FLAGCFG: nxt_rdata = flag_behaviour_config_ff;
        // pin levels, not drive values, so external drivers are seen too
        dgf_pkg::REG_CTRL:    nxt_rdata = {2'b00, od_pin_i}; // see [RULE_20]
        default:              nxt_rdata = 8'h00;
      endcase
    end
    // open-drain: a high value releases the pin, a low value pulls it down
    nxt_od = ctrl_ff[dgf_pkg::NUM_PINS-1:0];
    nxt_od[dgf_pkg::PIN_LOS] = los_det_i;
    nxt_od[dgf_pkg::PIN_TXF] = tx_fault_det_i;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_behaviour_config_ff <= dgf_pkg::FLAGCFG_RST;
      ctrl_ff  <= dgf_pkg::CTRL_RST;
      rdata_ff <= 8'h00;
      rvld_ff  <= 1'b0;
      od_ff    <= 6'h3F;
    end else begin
      flag_behaviour_config_ff <= nxt_flag_behaviour_config;
      ctrl_ff  <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      rvld_ff  <= nxt_rvld;
      od_ff    <= nxt_od;
    end
  end

  always_comb begin
    reg_rdata_o   = rdata_ff;
    reg_rvld_o    = rvld_ff;
    od_pin_o      = 6'h00;
    od_pin_oe_n_o = od_ff; // see [RULE_20]
    table_index_o = tif.index;
    tbl_addr_o    = tif.tbl_addr;
    tbl_page_o    = tif.tbl_page;
  end

  a_temp_hi_alarm: assert property ( // see [RULE_01]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_TEMP &&
    $signed(meas_data_i) > $signed(alm_hi_i[dgf_pkg::CH_TEMP]) |=> alarm_flags_a_ff[7])
    else $error("temperature high alarm flag not set");

  a_volt_lo_alarm: assert property ( // see [RULE_02]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_VOLT &&
    meas_data_i < alm_lo_i[dgf_pkg::CH_VOLT] |=> alarm_flags_a_ff[4])
    else $error("voltage low alarm flag not set");

  a_bias_hi_alarm: assert property ( // see [RULE_03]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_BIAS &&
    meas_data_i > alm_hi_i[dgf_pkg::CH_BIAS] |=> alarm_flags_a_ff[3])
    else $error("bias high alarm flag not set");

  a_txp_lo_warn: assert property ( // see [RULE_07]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_TXP &&
    meas_data_i < wrn_lo_i[dgf_pkg::CH_TXP] |=> warning_flags_a_ff[0])
    else $error("transmit power low warning flag not set");

  a_rxp_hi_alarm: assert property ( // see [RULE_05]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_RXP &&
    meas_data_i > alm_hi_i[dgf_pkg::CH_RXP] |=> alarm_flags_b_ff[7])
    else $error("receive power high alarm flag not set");

  a_rxp_lo_warn: assert property ( // see [RULE_08]
    meas_vld_i && meas_chan_i == dgf_pkg::CH_RXP &&
    meas_data_i < wrn_lo_i[dgf_pkg::CH_RXP] |=> warning_flags_b_ff[6])
    else $error("receive power low warning flag not set");

  a_read_clears: assert property ( // see [RULE_10]
    reg_rd_i && reg_addr_i == dgf_pkg::REG_ALARM_A && clr_on_rd && !meas_vld_i
    |=> alarm_flags_a_ff == 8'h00 && reg_rdata_o == $past(alarm_flags_a_ff))
    else $error("alarm read did not return and clear flags");

  a_txdis_clears: assert property ( // see [RULE_12]
    $fell(tx_disable_i) && !meas_vld_i |=>
    (alarm_flags_a_ff | alarm_flags_b_ff | warning_flags_a_ff | warning_flags_b_ff) == 8'h00)
    else $error("flags not cleared after transmit disable release");

  a_index_read: assert property ( // see [RULE_16]
    reg_rd_i && reg_addr_i == dgf_pkg::REG_INDEX |=> reg_rvld_o &&
    reg_rdata_o[6:0] == $past(tif.index))
    else $error("index register read mismatch");

  a_pin_level: assert property ( // see [RULE_20]
    reg_rd_i && reg_addr_i == dgf_pkg::REG_CTRL |=> reg_rdata_o[5:0] == $past(od_pin_i))
    else $error("control read does not show pin levels");
endmodule

// >>> dgf_host_model.sv
// host-side register master and open-drain pin wiring model
`timescale 1ns/10ps
module dgf_host_model (
  input  wire logic       clk_i,       // system clock
  input  wire logic [5:0] oe_n_i,      // device pin enables, low pulls low
  input  wire logic [5:0] ext_low_i,   // external drivers pulling low
  output logic            reg_rd_o,    // read strobe
  output logic            reg_wr_o,    // write strobe
  output logic [7:0]      reg_addr_o,  // register offset
  output logic [7:0]      reg_wdata_o, // write data
  output logic [5:0]      pin_lvl_o    // resolved pin level
);
  // pull-up on every pin: low as soon as anyone pulls
  assign pin_lvl_o = oe_n_i & ~ext_low_i;
  initial begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'hFF;
    reg_wdata_o = 8'h00;
  end
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_rd_o = rd;
    reg_wr_o = ~rd;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    // released bus must not keep the last value
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// >>> dgf_top_tb_top.sv
// self-checking bench for the diagnostic flag and table index block
`timescale 1ns/10ps
module dgf_top_tb_top;
  logic              clk_i, arst_n_i, meas_vld_i, tx_disable_i, los_det_i, tx_fault_det_i, pg;
  logic [2:0]        meas_chan_i;
  logic [15:0]       meas_data_i, note;
  dgf_pkg::dgf_thr_t alm_hi, alm_lo, wrn_hi, wrn_lo;
  logic              reg_rd, reg_wr, reg_rvld;
  logic [7:0]        reg_addr, reg_wdata, reg_rdata, bits, ra, ia, ob;
  logic [7:0]        degs[6] = '{8'h1E, 8'h20, 8'h21, 8'hD8, 8'h80, 8'h82};
  logic [6:0]        idxs[6] = '{7'h0F, 7'h0F, 7'h10, 7'h14, 7'h40, 7'h3F};
  logic [5:0]        pin_lvl, oe_n, ext_low;
  logic [6:0]        table_index;
  logic [31:0]       tbl_addr, ea;
  logic [3:0]        tbl_page;
  logic [15:0]       exp_q[$];
  int                mismatches, comparisons;
  integer            seed;

  dgf_host_model host (.clk_i(clk_i), .oe_n_i(oe_n), .ext_low_i(ext_low), .reg_rd_o(reg_rd),
    .reg_wr_o(reg_wr), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .pin_lvl_o(pin_lvl));
  dgf_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .meas_vld_i(meas_vld_i),
    .meas_chan_i(meas_chan_i), .meas_data_i(meas_data_i), .alm_hi_i(alm_hi), .alm_lo_i(alm_lo),
    .wrn_hi_i(wrn_hi), .wrn_lo_i(wrn_lo), .tx_disable_i(tx_disable_i), .los_det_i(los_det_i),
    .tx_fault_det_i(tx_fault_det_i), .reg_rd_i(reg_rd), .reg_wr_i(reg_wr),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
    .reg_rvld_o(reg_rvld), .od_pin_i(pin_lvl), .od_pin_o(), .od_pin_oe_n_o(oe_n),
    .table_index_o(table_index), .tbl_addr_o(tbl_addr), .tbl_page_o(tbl_page));

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({a, e});
    host.access(1'b1, a, 8'h00);
  endtask
  task automatic send(input logic [2:0] c, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    meas_vld_i = 1'b1;
    meas_chan_i = c;
    meas_data_i = d;
    @(posedge clk_i);
    #1;
    meas_vld_i = 1'b0;
    meas_data_i = ~d;
  endtask
  task automatic settle();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // read results pair with notes in issue order
  always @(posedge clk_i) begin
    if (reg_rvld === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("BAD rdata expected none seen %h", reg_rdata);
      end else begin
        note = exp_q.pop_front();
        check("rdata", {24'h0, note[7:0]}, {24'h0, reg_rdata});
      end
    end
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    seed = 32'hEE6F;
    {arst_n_i, meas_vld_i, tx_disable_i, meas_chan_i, meas_data_i} = '0;
    {los_det_i, tx_fault_det_i, ext_low} = 8'hC0;
    for (int c = 0; c < 5; c++) begin
      {alm_hi[c], wrn_hi[c], wrn_lo[c], alm_lo[c]} = 64'h0600_0400_0200_0100;
    end
    repeat (4) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    for (int r = 0; r < 6; r++) rd(r[7:0], 8'h00);
    rd(dgf_pkg::REG_CTRL, 8'h3F);
    rd(8'h07, 8'h00);
    for (int c = 0; c < 5; c++) begin
      send(c[2:0], 16'h0601 + 16'($random(seed) & 32'h0FFF));
      send(c[2:0], 16'($random(seed) & 32'h00FF));
      bits = (c == 4) ? 8'hC0 : (8'hC0 >> (2 * c));
      ra = (c == 4) ? 8'h01 : 8'h00;
      rd(ra, bits);
      rd(ra + 8'h02, bits);
      rd(ra, 8'h00);
    end
    send(3'h5, 16'hFFFF);
    rd(8'h00, 8'h00);
    tx_disable_i = 1'b1;
    send(dgf_pkg::CH_TEMP, 16'h1000);
    rd(8'h00, 8'h80);
    send(dgf_pkg::CH_TEMP, 16'h1000);
    tx_disable_i = 1'b0;
    settle();
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h00);
    host.access(1'b0, dgf_pkg::REG_FLAGCFG, 8'hF0);
    send(dgf_pkg::CH_TEMP, 16'h1000);
    rd(8'h00, 8'h80);
    rd(8'h00, 8'h80);
    rd(dgf_pkg::REG_FLAGCFG, 8'hF0);
    host.access(1'b0, dgf_pkg::REG_FLAGCFG, 8'h00);
    rd(8'h00, 8'h80);
    rd(8'h00, 8'h00);
    ext_low = 6'h10;
    host.access(1'b0, dgf_pkg::REG_CTRL, 8'h0A);
    settle();
    check("oe_n", 32'h3A, {26'h0, oe_n});
    rd(dgf_pkg::REG_CTRL, 8'h2A);
    {los_det_i, tx_fault_det_i, ext_low} = 8'h00;
    settle();
    rd(dgf_pkg::REG_CTRL, 8'h0A);
    // mid-run reset: earlier temperature results must not leak into the first average
    settle();
    arst_n_i = 1'b0;
    settle();
    arst_n_i = 1'b1;
    rd(dgf_pkg::REG_CTRL, 8'h0F);
    // 30, 32, 33, -40, -128, -126 degrees: 32 holds, -126 just crosses the lower midpoint
    for (int s = 0; s < 6; s++) begin
      for (int k = 0; k < 16; k++) begin
        send(dgf_pkg::CH_TEMP, {degs[s], 8'($random(seed))});
      end
      settle();
      ia = {1'b0, idxs[s]};
      pg = ia >= 8'h40;
      ob = pg ? ia - 8'h40 : ia;
      ea = pg ? {dgf_pkg::CONT_BHA, dgf_pkg::CONT_FLT, dgf_pkg::CONT_MOD, dgf_pkg::CONT_APC}
              : {dgf_pkg::BASE_BHA, dgf_pkg::BASE_FLT, dgf_pkg::BASE_MOD, dgf_pkg::BASE_APC};
      check("index", {25'h0, idxs[s]}, {25'h0, table_index});
      check("addr", ea + {4{ob}}, tbl_addr);
      check("page", {28'h0, {4{pg}}}, {28'h0, tbl_page});
    end
    host.access(1'b0, dgf_pkg::REG_INDEX, 8'h55);
    rd(dgf_pkg::REG_INDEX, 8'h3F);
    settle();
    if (exp_q.size() != 0) mismatches++;
    end_sim();
  end
endmodule
